// ==== hdl/mpe_pkg.sv ====
// constants, offsets and types shared by the memory controller event monitor
package mpe_pkg;

    // ==========================================================
    // channel count and event codes
    localparam int          NUM_CH          = 3;
    localparam logic [7:0]  EV_ISO_FULL     = 8'h28;
    localparam logic [7:0]  EV_PENDING      = 8'h29;
    localparam logic [7:0]  EV_NORMAL_FILL  = 8'h2a;
    localparam logic [7:0]  EV_ISO_FILL     = 8'h2b;
    localparam logic [7:0]  EV_NORMAL_READ  = 8'h2c;
    localparam logic [7:0]  EV_URGENT_READ  = 8'h2d;
    localparam logic [7:0]  EV_TOP_READ     = 8'h2e;
    localparam logic [7:0]  EV_LINE_WRITE   = 8'h2f;
    localparam logic [7:0]  EV_ROW_ACT      = 8'h60;
    localparam logic [7:0]  EV_ROW_CLOSE    = 8'h61;
    localparam logic [7:0]  EV_ROW_MISS     = 8'h62;
    localparam logic [7:0]  EV_COL_READ     = 8'h63;
    localparam logic [7:0]  EV_COL_WRITE    = 8'h64;
    localparam logic [7:0]  EV_REFRESH      = 8'h65;
    localparam logic [7:0]  EV_CLOSE_ALL    = 8'h66;

    // ==========================================================
    // register map, byte addresses within the slave window
    localparam logic [7:0]  CTL_OFS         = 8'h00;
    localparam logic [7:0]  CNT_OFS         = 8'h04;
    localparam logic [7:0]  CTR_STRIDE      = 8'h08;
    localparam logic [7:0]  FILL_OFS        = 8'h80;

    // ==========================================================
    // control register fields and reset values
    localparam int          CODE_LSB        = 0;
    localparam int          UMASK_LSB       = 8;
    localparam int          EN_BIT          = 22;
    localparam int          FILL_LANE       = 8;
    localparam logic [7:0]  CODE_RST        = 8'h00;
    localparam logic [7:0]  UMASK_RST       = 8'h00;
    localparam logic        EN_RST          = 1'b0;
    localparam logic [31:0] CNT_RST         = 32'h0000_0000;
    localparam logic [31:0] RDATA_RST       = 32'h0000_0000;

    // ==========================================================
    // bus slave states
    typedef enum logic [1:0] {
        BS_IDLE    = 2'b00,
        BS_WRITE   = 2'b01,
        BS_RD_WAIT = 2'b10,
        BS_RD_DONE = 2'b11
    } mpe_bus_state_t;

endpackage : mpe_pkg

// ==== hdl/mpe_counter.sv ====
// one programmable event counter with software load
`timescale 1ns/10ps
`default_nettype none
module mpe_counter #(
    parameter int CNT_W = 32,
    parameter int INC_W = 8
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    // control
    input  wire logic             en,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_val,
    input  wire logic [INC_W-1:0] inc,
    // count
    output logic      [CNT_W-1:0] count
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    // software load wins over the increment of the same cycle
    always_comb
    begin
        cnt_d = cnt_q;
        if (load)
            cnt_d = load_val;
        else if (en)
            cnt_d = cnt_q + CNT_W'(inc);
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            cnt_q <= CNT_W'(mpe_pkg::CNT_RST);
        else
            cnt_q <= cnt_d;
    end

    assign count = cnt_q;

endmodule : mpe_counter
`default_nettype wire

// ==== hdl/mpe_event_sel.sv ====
// event code and unit mask decode into a per-cycle increment
`timescale 1ns/10ps
`default_nettype none
module mpe_event_sel #(
    parameter int OCC_W = 6,
    parameter int INC_W = 8
) (
    // clock and reset, used by the checks only
    input  wire logic               sys_clk,
    input  wire logic               rstn,
    // selection
    input  wire logic [7:0]         code,
    input  wire logic [7:0]         umask,
    // queue fill per channel, channel 0 in the low slice
    input  wire logic [3*OCC_W-1:0] rdq_fill,
    input  wire logic [3*OCC_W-1:0] isoq_fill,
    // per channel events, bit n is channel n
    input  wire logic [2:0]         normal_read,
    input  wire logic [2:0]         urgent_read,
    input  wire logic [2:0]         top_read,
    input  wire logic [2:0]         full_wr,
    input  wire logic [2:0]         part_wr,
    input  wire logic [2:0]         rd_pend,
    input  wire logic [2:0]         wr_pend,
    input  wire logic [2:0]         iso_rd_full,
    input  wire logic [2:0]         iso_wr_full,
    input  wire logic [2:0]         row_act,
    input  wire logic [2:0]         row_close,
    input  wire logic [2:0]         row_miss,
    input  wire logic [2:0]         col_rd,
    input  wire logic [2:0]         col_rd_arc,
    input  wire logic [2:0]         col_wr,
    input  wire logic [2:0]         col_wr_arc,
    input  wire logic [2:0]         refresh,
    input  wire logic [2:0]         close_all,
    // increment for this cycle
    output logic      [INC_W-1:0]   inc
);

    logic [5:0]         vec;
    logic               occ_mode;
    logic [3*OCC_W-1:0] occ;

    always_comb
    begin
        vec      = 6'h00;
        occ_mode = 1'b0;
        occ      = rdq_fill;
        case (code)
            mpe_pkg::EV_NORMAL_FILL: begin occ_mode = 1'b1; occ = rdq_fill; end
            mpe_pkg::EV_ISO_FILL:    begin occ_mode = 1'b1; occ = isoq_fill; end
            mpe_pkg::EV_NORMAL_READ: vec = {3'h0, normal_read};
            mpe_pkg::EV_URGENT_READ: vec = {3'h0, urgent_read};
            mpe_pkg::EV_TOP_READ:    vec = {3'h0, top_read};
            mpe_pkg::EV_LINE_WRITE:  vec = {part_wr, full_wr};
            mpe_pkg::EV_PENDING:     vec = {wr_pend, rd_pend};
            mpe_pkg::EV_ISO_FULL:    vec = {iso_wr_full, iso_rd_full};
            mpe_pkg::EV_ROW_ACT:     vec = {3'h0, row_act};
            mpe_pkg::EV_ROW_CLOSE:   vec = {3'h0, row_close};
            mpe_pkg::EV_ROW_MISS:    vec = {3'h0, row_miss};
            // column commands interleave plain and auto close per channel
            mpe_pkg::EV_COL_READ:    vec = {col_rd_arc[2], col_rd[2], col_rd_arc[1],
                                            col_rd[1], col_rd_arc[0], col_rd[0]};
            mpe_pkg::EV_COL_WRITE:   vec = {col_wr_arc[2], col_wr[2], col_wr_arc[1],
                                            col_wr[1], col_wr_arc[0], col_wr[0]};
            mpe_pkg::EV_REFRESH:     vec = {3'h0, refresh};
            mpe_pkg::EV_CLOSE_ALL:   vec = {3'h0, close_all};
            default:                 vec = 6'h00;
        endcase
        inc = '0;
        // every selected sub-event adds in, so wide masks give totals
        for (int i = 0; i < 3; i++)
            if (occ_mode && umask[i])
                inc = inc + INC_W'(occ[i*OCC_W +: OCC_W]);
        for (int i = 0; i < 6; i++)
            if (!occ_mode && umask[i] && vec[i])
                inc = inc + INC_W'(1);
    end

    // ==========================================================
    // checks
    AST_NORMAL_FILL_CH0: assert property (@(posedge sys_clk) disable iff (!rstn)
        code == 8'h2a && umask == 8'h01 |-> inc == INC_W'(rdq_fill[OCC_W-1:0]))
        else $error("normal fill channel 0 increment wrong");
    AST_NORMAL_READ_ANY: assert property (@(posedge sys_clk) disable iff (!rstn)
        code == 8'h2c && umask == 8'h07 |-> inc == INC_W'($countones(normal_read)))
        else $error("normal read total wrong");
    AST_PART_WRITE_ANY: assert property (@(posedge sys_clk) disable iff (!rstn)
        code == 8'h2f && umask == 8'h38 |-> inc == INC_W'($countones(part_wr)))
        else $error("partial write total wrong");
    AST_WRITE_PENDING_CH0: assert property (@(posedge sys_clk) disable iff (!rstn)
        code == 8'h29 && umask == 8'h08 |-> inc == INC_W'(wr_pend[0]))
        else $error("write pending channel 0 wrong");
    AST_CHANNEL_ISOLATE: assert property (@(posedge sys_clk) disable iff (!rstn)
        code == 8'h60 && umask == 8'h02 |-> inc == INC_W'(row_act[1]))
        else $error("channel 1 activate leaks other channels");
    AST_COL_READ_ARC_CH0: assert property (@(posedge sys_clk) disable iff (!rstn)
        code == 8'h63 && umask == 8'h02 |-> inc == INC_W'(col_rd_arc[0]))
        else $error("auto close read channel 0 wrong");
    AST_COL_WRITE_CH2: assert property (@(posedge sys_clk) disable iff (!rstn)
        code == 8'h64 && umask == 8'h10 |-> inc == INC_W'(col_wr[2]))
        else $error("plain write channel 2 wrong");
    AST_ISO_WR_FULL_CH2: assert property (@(posedge sys_clk) disable iff (!rstn)
        code == 8'h28 && umask == 8'h20 |-> inc == INC_W'(iso_wr_full[2]))
        else $error("isochronous write full channel 2 wrong");

endmodule : mpe_event_sel
`default_nettype wire

// ==== hdl/mpe_perf_mon.sv ====
// memory controller event monitor: queue trackers, counters, ahb-lite slave
//
// Summary of operation
// - each of the three channels is watched on its own signals
// - code 2A adds normal read queue fill, mask bits pick channels
// - code 2C counts normal reads per channel, mask 07 all
// - code 2F counts full line writes, mask 07 all channels
// - code 2F mask 08/10/20 counts partial writes, 38 all
// - code 29 counts read pending (01-04) or write pending (08-20) cycles
// - code 60 counts row activates per channel
// - code 61 counts row closes per channel
// - code 62 counts row misses per channel
// - code 2B adds isochronous queue fill, mask 07 combined
// - code 2D counts urgent reads, mask 07 total
// - code 2E counts top urgency reads, mask 07 total
// - code 28 counts isochronous full cycles, reads low, writes high
// - code 63 counts column reads, odd bits are auto close
// - code 64 counts column writes, same layout as reads
// - code 65 counts refresh commands per channel
// - code 66 counts close-all commands per channel
`timescale 1ns/10ps
`default_nettype none
module mpe_perf_mon #(
    parameter int NUM_CTR = 2,
    parameter int CNT_W   = 32,
    parameter int OCC_W   = 6
) (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rstn,
    // ahb-lite slave
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic                       hready,
    input  wire logic [31:0]                hwdata,
    output logic      [31:0]                hrdata,
    output logic                            hreadyout,
    output logic                            hresp,
    // queue tracking
    input  wire logic                       bus_lock,
    input  wire logic [mpe_pkg::NUM_CH-1:0] rdq_insert,
    input  wire logic [mpe_pkg::NUM_CH-1:0] rdq_retire,
    input  wire logic [mpe_pkg::NUM_CH-1:0] isoq_insert,
    input  wire logic [mpe_pkg::NUM_CH-1:0] isoq_retire,
    // request and write events
    input  wire logic [mpe_pkg::NUM_CH-1:0] normal_read,
    input  wire logic [mpe_pkg::NUM_CH-1:0] urgent_read,
    input  wire logic [mpe_pkg::NUM_CH-1:0] top_urgency_read,
    input  wire logic [mpe_pkg::NUM_CH-1:0] full_line_write,
    input  wire logic [mpe_pkg::NUM_CH-1:0] partial_line_write,
    // queue levels
    input  wire logic [mpe_pkg::NUM_CH-1:0] read_pending,
    input  wire logic [mpe_pkg::NUM_CH-1:0] write_pending,
    input  wire logic [mpe_pkg::NUM_CH-1:0] isochronous_rd_full,
    input  wire logic [mpe_pkg::NUM_CH-1:0] isochronous_wr_full,
    // dram command events
    input  wire logic [mpe_pkg::NUM_CH-1:0] row_activate,
    input  wire logic [mpe_pkg::NUM_CH-1:0] row_close,
    input  wire logic [mpe_pkg::NUM_CH-1:0] row_miss,
    input  wire logic [mpe_pkg::NUM_CH-1:0] column_read,
    input  wire logic [mpe_pkg::NUM_CH-1:0] column_read_auto_row_close,
    input  wire logic [mpe_pkg::NUM_CH-1:0] column_write,
    input  wire logic [mpe_pkg::NUM_CH-1:0] column_write_auto_row_close,
    input  wire logic [mpe_pkg::NUM_CH-1:0] refresh_cmd,
    input  wire logic [mpe_pkg::NUM_CH-1:0] bank_close_all
);

    localparam int NQ    = 2 * mpe_pkg::NUM_CH;
    localparam int INC_W = OCC_W + 2;

    // ==========================================================
    // queue fill trackers, normal queues low, isochronous high
    logic [OCC_W-1:0]            occ_q [NQ];
    logic [OCC_W-1:0]            occ_d [NQ];
    logic [NQ-1:0]               q_ins;
    logic [NQ-1:0]               q_ret;
    logic [3*OCC_W-1:0]          rdq_fill;
    logic [3*OCC_W-1:0]          isoq_fill;

    assign q_ins = {isoq_insert, rdq_insert};
    assign q_ret = {isoq_retire, rdq_retire};

    // the lock resets the trackers, since a tracker started mid-flight
    // would carry entries whose insert it never saw
    always_comb
    begin
        for (int q = 0; q < NQ; q++)
        begin
            occ_d[q] = occ_q[q];
            if (bus_lock)
                occ_d[q] = '0;
            else if (q_ins[q] && !q_ret[q] && occ_q[q] != '1)
                occ_d[q] = occ_q[q] + OCC_W'(1);
            else if (q_ret[q] && !q_ins[q] && occ_q[q] != '0)
                occ_d[q] = occ_q[q] - OCC_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int q = 0; q < NQ; q++)
                occ_q[q] <= '0;
        end
        else
        begin
            for (int q = 0; q < NQ; q++)
                occ_q[q] <= occ_d[q];
        end
    end

    always_comb
    begin
        for (int c = 0; c < mpe_pkg::NUM_CH; c++)
        begin
            rdq_fill[c*OCC_W +: OCC_W]  = occ_q[c];
            isoq_fill[c*OCC_W +: OCC_W] = occ_q[c + mpe_pkg::NUM_CH];
        end
    end

    // ==========================================================
    // ahb-lite slave: writes take no wait, reads take one wait state
    mpe_pkg::mpe_bus_state_t st_q;
    mpe_pkg::mpe_bus_state_t st_d;
    logic [7:0]              addr_q;
    logic [7:0]              addr_d;
    logic [31:0]             hrdata_q;
    logic [31:0]             hrdata_d;
    logic [31:0]             rd_mux;
    logic                    accept;
    logic                    wr_fire;

    assign accept  = hsel && htrans[1] && hready;
    assign wr_fire = (st_q == mpe_pkg::BS_WRITE);

    always_comb
    begin
        st_d     = st_q;
        addr_d   = addr_q;
        hrdata_d = hrdata_q;
        case (st_q)
            mpe_pkg::BS_RD_WAIT:
            begin
                hrdata_d = rd_mux;
                st_d     = mpe_pkg::BS_RD_DONE;
            end
            mpe_pkg::BS_IDLE, mpe_pkg::BS_WRITE, mpe_pkg::BS_RD_DONE:
            begin
                if (accept)
                begin
                    addr_d = haddr[7:0];
                    st_d   = hwrite ? mpe_pkg::BS_WRITE : mpe_pkg::BS_RD_WAIT;
                end
                else
                    st_d = mpe_pkg::BS_IDLE;
            end
            default: st_d = mpe_pkg::BS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q     <= mpe_pkg::BS_IDLE;
            addr_q   <= 8'h00;
            hrdata_q <= mpe_pkg::RDATA_RST;
        end
        else
        begin
            st_q     <= st_d;
            addr_q   <= addr_d;
            hrdata_q <= hrdata_d;
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = (st_q != mpe_pkg::BS_RD_WAIT);
    assign hresp     = 1'b0;

    // ==========================================================
    // event selection registers
    logic [7:0]       code_q  [NUM_CTR];
    logic [7:0]       code_d  [NUM_CTR];
    logic [7:0]       umask_q [NUM_CTR];
    logic [7:0]       umask_d [NUM_CTR];
    logic [NUM_CTR-1:0] en_q;
    logic [NUM_CTR-1:0] en_d;
    logic [NUM_CTR-1:0] cnt_load;
    logic [CNT_W-1:0] cnt_w   [NUM_CTR];
    logic [INC_W-1:0] inc_w   [NUM_CTR];

    always_comb
    begin
        for (int i = 0; i < NUM_CTR; i++)
        begin
            code_d[i]   = code_q[i];
            umask_d[i]  = umask_q[i];
            en_d[i]     = en_q[i];
            cnt_load[i] = wr_fire && addr_q == 8'(mpe_pkg::CNT_OFS + i * mpe_pkg::CTR_STRIDE);
            if (wr_fire && addr_q == 8'(mpe_pkg::CTL_OFS + i * mpe_pkg::CTR_STRIDE))
            begin
                code_d[i]  = hwdata[mpe_pkg::CODE_LSB +: 8];
                umask_d[i] = hwdata[mpe_pkg::UMASK_LSB +: 8];
                en_d[i]    = hwdata[mpe_pkg::EN_BIT];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < NUM_CTR; i++)
            begin
                code_q[i]  <= mpe_pkg::CODE_RST;
                umask_q[i] <= mpe_pkg::UMASK_RST;
                en_q[i]    <= mpe_pkg::EN_RST;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_CTR; i++)
            begin
                code_q[i]  <= code_d[i];
                umask_q[i] <= umask_d[i];
                en_q[i]    <= en_d[i];
            end
        end
    end

    // read mux; unmapped or misaligned addresses read as zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        for (int i = 0; i < NUM_CTR; i++)
        begin
            if (addr_q == 8'(mpe_pkg::CTL_OFS + i * mpe_pkg::CTR_STRIDE))
            begin
                rd_mux[mpe_pkg::CODE_LSB +: 8]  = code_q[i];
                rd_mux[mpe_pkg::UMASK_LSB +: 8] = umask_q[i];
                rd_mux[mpe_pkg::EN_BIT]         = en_q[i];
            end
            if (addr_q == 8'(mpe_pkg::CNT_OFS + i * mpe_pkg::CTR_STRIDE))
                rd_mux = 32'(cnt_w[i]);
        end
        if (addr_q == mpe_pkg::FILL_OFS)
        begin
            for (int c = 0; c < mpe_pkg::NUM_CH; c++)
                rd_mux[c*mpe_pkg::FILL_LANE +: mpe_pkg::FILL_LANE] = 8'(occ_q[c]);
        end
    end

    // ==========================================================
    // counters, each with its own event decoder
    for (genvar g = 0; g < NUM_CTR; g++)
    begin : g_ctr
        mpe_event_sel #(
            .OCC_W (OCC_W),
            .INC_W (INC_W)
        ) u_sel (
            .sys_clk     (sys_clk),
            .rstn        (rstn),
            .code        (code_q[g]),
            .umask       (umask_q[g]),
            .rdq_fill    (rdq_fill),
            .isoq_fill   (isoq_fill),
            .normal_read (normal_read),
            .urgent_read (urgent_read),
            .top_read    (top_urgency_read),
            .full_wr     (full_line_write),
            .part_wr     (partial_line_write),
            .rd_pend     (read_pending),
            .wr_pend     (write_pending),
            .iso_rd_full (isochronous_rd_full),
            .iso_wr_full (isochronous_wr_full),
            .row_act     (row_activate),
            .row_close   (row_close),
            .row_miss    (row_miss),
            .col_rd      (column_read),
            .col_rd_arc  (column_read_auto_row_close),
            .col_wr      (column_write),
            .col_wr_arc  (column_write_auto_row_close),
            .refresh     (refresh_cmd),
            .close_all   (bank_close_all),
            .inc         (inc_w[g])
        );

        mpe_counter #(
            .CNT_W (CNT_W),
            .INC_W (INC_W)
        ) u_cnt (
            .sys_clk  (sys_clk),
            .rstn     (rstn),
            .en       (en_q[g]),
            .load     (cnt_load[g]),
            .load_val (hwdata[CNT_W-1:0]),
            .inc      (inc_w[g]),
            .count    (cnt_w[g])
        );
    end

    // ==========================================================
    // checks
    AST_COUNT_STEP: assert property (@(posedge sys_clk) disable iff (!rstn)
        en_q[0] && !cnt_load[0] |=> cnt_w[0] == CNT_W'($past(cnt_w[0]) + CNT_W'($past(inc_w[0]))))
        else $error("counter 0 did not advance by its increment");
    AST_COUNT_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
        !en_q[0] && !cnt_load[0] |=> $stable(cnt_w[0]))
        else $error("disabled counter 0 moved");
    AST_LOCK_CLEARS: assert property (@(posedge sys_clk) disable iff (!rstn)
        bus_lock |=> occ_q[0] == '0 && occ_q[mpe_pkg::NUM_CH] == '0)
        else $error("bus lock did not clear the queue trackers");
    AST_READ_WAIT: assert property (@(posedge sys_clk) disable iff (!rstn)
        accept && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not exactly one wait state");

endmodule : mpe_perf_mon
`default_nettype wire

// ==== verification/mpe_testbench.sv ====
// self-checking testbench for the memory controller event monitor
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        sys_clk;
    logic        rstn;
    logic        hsel;
    logic        hwrite;
    logic        bus_lock;
    logic        hreadyout;
    logic        hresp;
    logic [1:0]  htrans;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [31:0] exp_cnt;
    logic [65:0] evs;
    logic [7:0]  codes[15];
    int unsigned num_errors;
    int unsigned compares;
    int unsigned fq[6];

    // tracker pulses sit in evs[11:0], the 18 event groups of three channels above them
    mpe_perf_mon u_dut (
        .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .bus_lock(bus_lock), .rdq_insert(evs[2:0]), .isoq_insert(evs[5:3]),
        .rdq_retire(evs[8:6]), .isoq_retire(evs[11:9]), .normal_read(evs[14:12]), .urgent_read(evs[17:15]),
        .top_urgency_read(evs[20:18]), .full_line_write(evs[23:21]), .partial_line_write(evs[26:24]),
        .read_pending(evs[29:27]), .write_pending(evs[32:30]), .isochronous_rd_full(evs[35:33]),
        .isochronous_wr_full(evs[38:36]), .row_activate(evs[41:39]), .row_close(evs[44:42]),
        .row_miss(evs[47:45]), .column_read(evs[50:48]), .column_read_auto_row_close(evs[53:51]),
        .column_write(evs[56:54]), .column_write_auto_row_close(evs[59:57]), .refresh_cmd(evs[62:60]),
        .bank_close_all(evs[65:63]));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // expectation and reporting
    function automatic logic [31:0] inc_of(input logic [7:0] c, input logic [7:0] m);
        logic [31:0] s;
        logic [9:0]  ix;
        s = 32'h0;
        case (c)
            mpe_pkg::EV_ISO_FULL:    ix = {5'd11, 5'd12};
            mpe_pkg::EV_PENDING:     ix = {5'd9, 5'd10};
            mpe_pkg::EV_NORMAL_READ: ix = {5'd4, 5'd0};
            mpe_pkg::EV_URGENT_READ: ix = {5'd5, 5'd0};
            mpe_pkg::EV_TOP_READ:    ix = {5'd6, 5'd0};
            mpe_pkg::EV_LINE_WRITE:  ix = {5'd7, 5'd8};
            mpe_pkg::EV_ROW_ACT:     ix = {5'd13, 5'd0};
            mpe_pkg::EV_ROW_CLOSE:   ix = {5'd14, 5'd0};
            mpe_pkg::EV_ROW_MISS:    ix = {5'd15, 5'd0};
            mpe_pkg::EV_COL_READ:    ix = {5'd16, 5'd17};
            mpe_pkg::EV_COL_WRITE:   ix = {5'd18, 5'd19};
            mpe_pkg::EV_REFRESH:     ix = {5'd20, 5'd0};
            mpe_pkg::EV_CLOSE_ALL:   ix = {5'd21, 5'd0};
            default:                 ix = 10'h0;
        endcase
        for (int k = 0; k < 3; k++)
            if (c == mpe_pkg::EV_NORMAL_FILL || c == mpe_pkg::EV_ISO_FILL)
                s += m[k] ? 32'(fq[k + 3 * c[0]]) : 32'h0;
            else if (c == mpe_pkg::EV_COL_READ || c == mpe_pkg::EV_COL_WRITE)
                s += 32'(m[2*k] & evs[3*ix[9:5]+k]) + 32'(m[2*k+1] & evs[3*ix[4:0]+k]);
            else
                s += 32'(m[k] & evs[3*ix[9:5]+k]) + 32'(m[k+3] & evs[3*ix[4:0]+k]);
        return s;
    endfunction : inc_of

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic end_of_test;
        if (num_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    // ==========================================================
    // ahb-lite master and scenarios
    // ready and read data are taken at the rising edge that samples them
    task automatic wait_rdy;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
        chk(32'(hresp), 32'h0);
    endtask : wait_rdy

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask : bus

    task automatic run_test(input int n, input logic [7:0] c, input logic [7:0] m);
        logic [7:0] a;
        a = 8'(n) * mpe_pkg::CTR_STRIDE;
        exp_cnt = $urandom;
        bus(1'b1, a + mpe_pkg::CTL_OFS, {9'h0, 1'b1, 6'h0, m, c});
        bus(1'b1, a + mpe_pkg::CNT_OFS, exp_cnt);
        for (int i = 0; i < 40; i++)
        begin
            @(posedge sys_clk);
            exp_cnt += inc_of(c, m);
            for (int q = 0; q < 6; q++)
                fq[q] = bus_lock ? 0 : (evs[q] && !evs[q+6] && fq[q] < 63) ? fq[q] + 1 :
                        (evs[q+6] && !evs[q] && fq[q] > 0) ? fq[q] - 1 : fq[q];
            evs <= (i < 38) ? 66'({$urandom, $urandom, $urandom}) : 66'h0;
            bus_lock <= (i == 38);
        end
        bus(1'b0, a + mpe_pkg::CNT_OFS, 32'h0);
        chk(rd, exp_cnt);
    endtask : run_test

    initial
    begin
        {hsel, hwrite, bus_lock, htrans, haddr, hwdata, evs} = '0;
        rstn = 1'b0;
        void'($urandom(53));
        codes = '{mpe_pkg::EV_ISO_FULL, mpe_pkg::EV_PENDING, mpe_pkg::EV_NORMAL_FILL, mpe_pkg::EV_ISO_FILL,
                  mpe_pkg::EV_NORMAL_READ, mpe_pkg::EV_URGENT_READ, mpe_pkg::EV_TOP_READ, mpe_pkg::EV_LINE_WRITE,
                  mpe_pkg::EV_ROW_ACT, mpe_pkg::EV_ROW_CLOSE, mpe_pkg::EV_ROW_MISS, mpe_pkg::EV_COL_READ,
                  mpe_pkg::EV_COL_WRITE, mpe_pkg::EV_REFRESH, mpe_pkg::EV_CLOSE_ALL};
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        bus(1'b0, mpe_pkg::CTL_OFS, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'hf0, 32'h0);
        chk(rd, 32'h0);
        // first pass with every defined mask bit set, second with random masks
        for (int t = 0; t < 30; t++)
            run_test(t % 2, codes[t % 15], (t < 15 ? 8'hff : 8'($urandom)) &
                     (codes[t % 15] inside {8'h28, 8'h29, 8'h2f, 8'h63, 8'h64} ? 8'h3f : 8'h07));
        // corner masks that single out one sub-event each, 38 the three partial writes
        run_test(0, mpe_pkg::EV_NORMAL_FILL, 8'h01);
        run_test(1, mpe_pkg::EV_LINE_WRITE, 8'h38);
        run_test(0, mpe_pkg::EV_PENDING, 8'h08);
        run_test(1, mpe_pkg::EV_ROW_ACT, 8'h02);
        run_test(0, mpe_pkg::EV_COL_READ, 8'h02);
        run_test(1, mpe_pkg::EV_COL_WRITE, 8'h10);
        run_test(0, mpe_pkg::EV_ISO_FULL, 8'h20);
        // trackers start cleared; two insert cycles leave fills of 2, 2 and 1
        evs <= 66'h7;
        @(posedge sys_clk);
        evs <= 66'h3;
        @(posedge sys_clk);
        evs <= 66'h0;
        bus(1'b0, mpe_pkg::FILL_OFS, 32'h0);
        chk(rd, 32'h0001_0202);
        end_of_test();
    end

    initial
    begin
        #100000;
        num_errors++;
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
